//--- logic/dsrc_defs.svh
// Purpose: Shared constants of the reference state controller
// Assumes: 100 MHz system clock
// Notes:   Times kept in their own unit; cycle counts derive from them
`ifndef DSRC_DEFS_SVH
`define DSRC_DEFS_SVH
// System clock rate
`define DSRC_CLK_HZ      100000000
`define DSRC_MS_HZ       1000
// Frame pulse rate
`define DSRC_FRAME_HZ    8000
// Mode selection codes {hi, lo}
`define DSRC_MODE_NORMAL 2'h0
`define DSRC_MODE_HOLD   2'h1
`define DSRC_MODE_FREE   2'h2
`define DSRC_MODE_RSVD   2'h3
// Reference rate codes {hi, lo}
`define DSRC_RATE_19M    2'h0
`define DSRC_RATE_8K     2'h1
`define DSRC_RATE_1M5    2'h2
`define DSRC_RATE_2M     2'h3
// Nominal reference rates in Hz
`define DSRC_HZ_19M      32'd19440000
`define DSRC_HZ_8K       32'd8000
`define DSRC_HZ_1M5      32'd1544000
`define DSRC_HZ_2M       32'd2048000
// Offset monitor limit and refresh time
`define DSRC_PPM_LIMIT   64'd12
`define DSRC_PPM_SCALE   64'd1000000
`define DSRC_MON_MS      2000
// Frequency word store interval
`define DSRC_STORE_MS    30
// Capture window in frames, its last index and edge slack
`define DSRC_CAP_FRAMES  16
`define DSRC_CAP_LAST    4'hf
`define DSRC_CAP_SLACK   32'd2
// Frequency word reset value
`define DSRC_RESET_WORD  32'h0
`endif

//--- logic/dsrc_pkg.sv
// Purpose: Types of the reference state controller
// Assumes: dsrc_defs.svh on the include path
// Notes:   Rate decode shared by top and monitors
package dsrc_pkg;
  `include "dsrc_defs.svh"
  typedef enum logic [2:0] {ST_FREERUN, ST_NORMAL, ST_AUTOHOLD, ST_HOLDOVER,
                            ST_SHORTHOLD} dsrc_state_e;
  typedef enum logic [1:0] {SRC_LOOP, SRC_STORED, SRC_MASTER} dsrc_src_e;
  // Nominal reference rate from its two-bit code
  function automatic logic [31:0] dsrc_rate_hz(input logic [1:0] code);
    unique case (code)
      `DSRC_RATE_19M: dsrc_rate_hz = `DSRC_HZ_19M;
      `DSRC_RATE_8K:  dsrc_rate_hz = `DSRC_HZ_8K;
      `DSRC_RATE_1M5: dsrc_rate_hz = `DSRC_HZ_1M5;
      `DSRC_RATE_2M:  dsrc_rate_hz = `DSRC_HZ_2M;
    endcase
  endfunction
endpackage

//--- logic/dsrc_edge_pick.sv
// Purpose: Active edge detector for one reference input
// Assumes: Reference already synchronous to clk
// Notes:   One-cycle pulse per active edge
`timescale 1ns/100ps
module dsrc_edge_pick import dsrc_pkg::*; (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic refIn,
  input  wire logic riseSel,
  output logic      edgePulse
);
  logic refPrev_q;

  // Previous level and edge pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      refPrev_q <= refIn; // No false edge after reset
      edgePulse <= 1'b0;
    end else begin
      refPrev_q <= refIn;
      edgePulse <= riseSel ? (refIn & ~refPrev_q) : (~refIn & refPrev_q);
    end
  end
endmodule

//--- logic/dsrc_offset_mon.sv
// Purpose: Frequency offset monitor for one reference
// Assumes: Edge pulses at most one per clock
// Notes:   Flag refreshed only at the end of each gate window
`timescale 1ns/100ps
`include "dsrc_defs.svh"
module dsrc_offset_mon import dsrc_pkg::*; #(
  parameter int unsigned GATE_CYCLES = `DSRC_MON_MS * (`DSRC_CLK_HZ / `DSRC_MS_HZ)
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        edgePulse,
  input  wire logic [31:0] rateHz,
  output logic             offsetFlag
);
  logic [31:0] gateCnt_q;
  logic [31:0] edgeCnt_q;
  logic        gateEnd;
  logic [63:0] expected;
  logic [63:0] diff;

  assign gateEnd  = (gateCnt_q == 32'(GATE_CYCLES - 1));
  assign expected = (64'(rateHz) * 64'(GATE_CYCLES)) / 64'(`DSRC_CLK_HZ);
  assign diff     = (64'(edgeCnt_q) > expected) ? 64'(edgeCnt_q) - expected
                                                : expected - 64'(edgeCnt_q);

  // Gate timer
  always_ff @(posedge clk) begin
    if (rst || gateEnd) gateCnt_q <= 32'h0;
    else gateCnt_q <= gateCnt_q + 32'h1;
  end

  // Edge count within the gate; an edge on the last cycle opens the next gate
  always_ff @(posedge clk) begin
    if (rst) edgeCnt_q <= 32'h0;
    else if (gateEnd) edgeCnt_q <= 32'(edgePulse);
    else edgeCnt_q <= edgeCnt_q + 32'(edgePulse);
  end

  // Offset verdict once per gate
  always_ff @(posedge clk) begin
    if (rst) offsetFlag <= 1'b0;
    else if (gateEnd)
      offsetFlag <= (diff * `DSRC_PPM_SCALE) > (expected * `DSRC_PPM_LIMIT);
  end
endmodule

//--- logic/dsrc_state_ctrl.sv
// Purpose: Operating state machine and reference handling of the timing loop
// Assumes: All pins synchronous to clk; frame pulse from the output divider
// Notes:   State moves only on a frame pulse rising edge
`timescale 1ns/100ps
`include "dsrc_defs.svh"
// Contract
// - Every state change happens on the frame pulse rising edge.
// - Mode code 00 Normal, 01 Holdover, 10 Freerun, 11 reserved.
// - Normal moves to Auto-Holdover when the selected reference is invalid.
// - Auto-Holdover returns to Normal when reference valid and no select change.
// - Select change in Auto-Holdover goes to Short Holdover, absorption off.
// - Select change in Normal goes to Short Holdover, absorption off.
// - Short Holdover without further change adopts new reference, back to Normal.
// - Any state change clears absorption, except holdover kinds into Normal.
// - Holdover kinds into Normal take absorption from the enable input.
// - Normal indicator high while in Normal.
// - Fast acquire input high selects fast lock submode of Normal.
// - Store word alternately every 30 ms; holdover uses the 30-60 ms one.
// - Hold indicator high while in Holdover.
// - Freerun uses the master oscillator only and ignores references.
// - Freerun indicator high while in Freerun.
// - Rate code 00 19.44M, 01 8k, 10 1.544M, 11 2.048M.
// - Rate code changes take effect only through a reset.
// - Falling edge active except rising edge at 19.44 MHz.
// - Select 0 routes reference A, select 1 routes reference B.
// - Each reference flagged when off nominal by more than 12 ppm.
// - Offset flags refreshed every 2 seconds.
// - Selected reference invalid when outside capture range or lost.
module dsrc_state_ctrl import dsrc_pkg::*; #(
  parameter int unsigned MON_CYCLES   = `DSRC_MON_MS * (`DSRC_CLK_HZ / `DSRC_MS_HZ),
  parameter int unsigned STORE_CYCLES = `DSRC_STORE_MS * (`DSRC_CLK_HZ / `DSRC_MS_HZ)
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        framePulse8k,
  input  wire logic        opStatePickLo,
  input  wire logic        opStatePickHi,
  input  wire logic        refSelect,
  input  wire logic        phaseStepAbsorbEnable,
  input  wire logic        fastAcquireEnable,
  input  wire logic        ref0RatePickLo,
  input  wire logic        ref0RatePickHi,
  input  wire logic        ref1RatePickLo,
  input  wire logic        ref1RatePickHi,
  input  wire logic        referenceA,
  input  wire logic        referenceB,
  input  wire logic        loopLocked,
  input  wire logic [31:0] freqWord,
  output logic             normalInd,
  output logic             holdInd,
  output logic             freerunInd,
  output logic             fastLockOn,
  output logic             absorbOn,
  output logic             activeRef,
  output logic             selRefPulse,
  output dsrc_src_e        dcoSource,
  output logic [31:0]      heldWord,
  output logic             refInvalid,
  output logic             refAOffsetFlag,
  output logic             refBOffsetFlag
);
  dsrc_state_e state_q;
  dsrc_state_e state_d;
  logic [1:0]  modeCode;
  logic [1:0]  refIn;
  logic [1:0]  edgeP;
  logic [1:0]  offFlag;
  logic [1:0]  rateIn [2];
  logic [1:0]  rateCode_q [2];
  logic        framePrev_q;
  logic        frameRise;
  logic        selPrev_q;
  logic        selToggle;
  logic        selSeen_q;
  logic        selSeen;
  logic        stateMove;
  logic        fromHold;
  logic        inHold_q;
  logic        inHold_d;
  logic [3:0]  capFrame_q;
  logic [31:0] capEdge_q;
  logic [31:0] capExpect;
  logic [31:0] capDiff;
  logic [31:0] storeCnt_q;
  logic        storeTick;
  logic [31:0] slot_q [2];
  logic        wrPtr_q;
  logic [31:0] olderWord;

  assign modeCode = {opStatePickHi, opStatePickLo};
  assign refIn    = {referenceB, referenceA};
  assign rateIn[0] = {ref0RatePickHi, ref0RatePickLo};
  assign rateIn[1] = {ref1RatePickHi, ref1RatePickLo};

  // Per-reference rate latch, edge picker and offset monitor
  for (genvar i = 0; i < 2; i++) begin : gChan
    // Rate pins only sampled while reset is held
    always_ff @(posedge clk) begin
      if (rst) rateCode_q[i] <= rateIn[i];
    end

    dsrc_edge_pick uPick (
      .clk       (clk),
      .rst       (rst),
      .refIn     (refIn[i]),
      .riseSel   (rateCode_q[i] == `DSRC_RATE_19M),
      .edgePulse (edgeP[i])
    );

    dsrc_offset_mon #(
      .GATE_CYCLES (MON_CYCLES)
    ) uMon (
      .clk        (clk),
      .rst        (rst),
      .edgePulse  (edgeP[i]),
      .rateHz     (dsrc_rate_hz(rateCode_q[i])),
      .offsetFlag (offFlag[i])
    );
  end

  assign refAOffsetFlag = offFlag[0];
  assign refBOffsetFlag = offFlag[1];

  // Frame pulse edge
  always_ff @(posedge clk) begin
    if (rst) framePrev_q <= 1'b0;
    else framePrev_q <= framePulse8k;
  end
  assign frameRise = framePulse8k & ~framePrev_q;

  // Select transition capture; a toggle on the frame edge counts for that decision
  assign selToggle = (refSelect != selPrev_q);
  assign selSeen   = selSeen_q | selToggle;
  always_ff @(posedge clk) begin
    if (rst) begin
      selPrev_q <= refSelect;
      selSeen_q <= 1'b0;
    end else begin
      selPrev_q <= refSelect;
      selSeen_q <= ~frameRise & (selToggle | selSeen_q);
    end
  end

  // Capture range check on the selected reference over a frame window
  assign capExpect = dsrc_rate_hz(rateCode_q[activeRef]) /
                     32'(`DSRC_FRAME_HZ / `DSRC_CAP_FRAMES);
  assign capDiff   = (capEdge_q > capExpect) ? capEdge_q - capExpect
                                             : capExpect - capEdge_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      capFrame_q <= 4'h0;
      capEdge_q  <= 32'h0;
      refInvalid <= 1'b0;
    end else if (frameRise && capFrame_q == `DSRC_CAP_LAST) begin
      capFrame_q <= 4'h0;
      capEdge_q  <= 32'(edgeP[activeRef]);
      refInvalid <= capDiff > `DSRC_CAP_SLACK;
    end else begin
      capFrame_q <= capFrame_q + 4'(frameRise);
      capEdge_q  <= capEdge_q + 32'(edgeP[activeRef]);
    end
  end

  // Next operating state
  always_comb begin
    state_d = state_q;
    if (frameRise) begin
      unique case (modeCode)
        `DSRC_MODE_FREE: state_d = ST_FREERUN;
        `DSRC_MODE_HOLD: state_d = ST_HOLDOVER;
        `DSRC_MODE_RSVD: state_d = state_q;
        `DSRC_MODE_NORMAL: begin
          unique case (state_q)
            ST_FREERUN, ST_HOLDOVER: state_d = ST_NORMAL;
            ST_NORMAL: begin
              if (selSeen) state_d = ST_SHORTHOLD;
              else if (refInvalid) state_d = ST_AUTOHOLD;
            end
            ST_AUTOHOLD: begin
              if (selSeen) state_d = ST_SHORTHOLD;
              else if (!refInvalid) state_d = ST_NORMAL;
            end
            ST_SHORTHOLD: begin
              if (!selSeen) state_d = ST_NORMAL;
            end
          endcase
        end
      endcase
    end
  end

  // State register; reset leaves the loop in Freerun
  always_ff @(posedge clk) begin
    if (rst) state_q <= ST_FREERUN;
    else state_q <= state_d;
  end

  assign stateMove = (state_d != state_q);
  assign fromHold  = (state_q == ST_HOLDOVER) || (state_q == ST_AUTOHOLD) ||
                     (state_q == ST_SHORTHOLD);

  // Phase step absorption gating
  always_ff @(posedge clk) begin
    if (rst) absorbOn <= 1'b0;
    else if (stateMove) begin
      if (state_d == ST_NORMAL && fromHold) absorbOn <= phaseStepAbsorbEnable;
      else absorbOn <= 1'b0;
    end
  end

  // Active reference choice
  always_ff @(posedge clk) begin
    if (rst) activeRef <= refSelect;
    else if (state_q == ST_SHORTHOLD && state_d == ST_NORMAL) activeRef <= refSelect;
    else if (frameRise && (state_d == ST_FREERUN || state_d == ST_HOLDOVER))
      activeRef <= refSelect;
  end

  // Selected reference routed onward only while tracking
  always_ff @(posedge clk) begin
    if (rst) selRefPulse <= 1'b0;
    else selRefPulse <= (state_d == ST_NORMAL) & edgeP[activeRef];
  end

  // Status indicators follow the next state
  always_ff @(posedge clk) begin
    if (rst) begin
      normalInd  <= 1'b0;
      holdInd    <= 1'b0;
      freerunInd <= 1'b1;
      fastLockOn <= 1'b0;
    end else begin
      normalInd  <= (state_d == ST_NORMAL);
      holdInd    <= (state_d == ST_HOLDOVER);
      freerunInd <= (state_d == ST_FREERUN);
      fastLockOn <= (state_d == ST_NORMAL) & fastAcquireEnable;
    end
  end

  // Oscillator source choice
  always_ff @(posedge clk) begin
    if (rst) dcoSource <= SRC_MASTER;
    else if (state_d == ST_FREERUN) dcoSource <= SRC_MASTER;
    else if (state_d == ST_NORMAL) dcoSource <= SRC_LOOP;
    else dcoSource <= SRC_STORED;
  end

  // Store interval timer, runs only while locked in Normal
  assign storeTick = (storeCnt_q == 32'(STORE_CYCLES - 1));
  always_ff @(posedge clk) begin
    if (rst || state_q != ST_NORMAL || !loopLocked || storeTick) storeCnt_q <= 32'h0;
    else storeCnt_q <= storeCnt_q + 32'h1;
  end

  // Alternating word slots; the write pointer marks the older slot
  assign olderWord = slot_q[wrPtr_q];
  always_ff @(posedge clk) begin
    if (rst) begin
      slot_q[0] <= `DSRC_RESET_WORD;
      slot_q[1] <= `DSRC_RESET_WORD;
      wrPtr_q   <= 1'b0;
    end else if (storeTick) begin
      slot_q[wrPtr_q] <= freqWord;
      wrPtr_q         <= ~wrPtr_q;
    end
  end

  // Held word loaded on entry to any holdover kind
  assign inHold_d = (state_d == ST_HOLDOVER) || (state_d == ST_AUTOHOLD) ||
                    (state_d == ST_SHORTHOLD);
  always_ff @(posedge clk) begin
    if (rst) begin
      inHold_q <= 1'b0;
      heldWord <= `DSRC_RESET_WORD;
    end else begin
      inHold_q <= inHold_d;
      if (inHold_d && !inHold_q) heldWord <= olderWord;
    end
  end

  // Checks on state behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_ON_FRAME: assert property (
    (state_q != $past(state_q)) |-> $past(frameRise))
    else $error("state moved without frame edge");
  AST_FREE_CODE: assert property (
    frameRise && modeCode == `DSRC_MODE_FREE |=> state_q == ST_FREERUN && freerunInd)
    else $error("freerun code not obeyed");
  AST_HOLD_CODE: assert property (
    frameRise && modeCode == `DSRC_MODE_HOLD |=> state_q == ST_HOLDOVER && holdInd)
    else $error("holdover code not obeyed");
  AST_AUTO_ENTER: assert property (
    frameRise && modeCode == `DSRC_MODE_NORMAL && state_q == ST_NORMAL && !selSeen &&
    refInvalid |=> state_q == ST_AUTOHOLD && dcoSource == SRC_STORED)
    else $error("invalid reference not held over");
  AST_AUTO_RETURN: assert property (
    frameRise && modeCode == `DSRC_MODE_NORMAL && state_q == ST_AUTOHOLD && !selSeen &&
    !refInvalid |=> state_q == ST_NORMAL)
    else $error("auto holdover did not return");
  AST_AUTO_SHORT: assert property (
    frameRise && modeCode == `DSRC_MODE_NORMAL && state_q == ST_AUTOHOLD && selSeen
    |=> state_q == ST_SHORTHOLD && !absorbOn)
    else $error("select change in auto holdover missed");
  AST_NORMAL_SHORT: assert property (
    frameRise && modeCode == `DSRC_MODE_NORMAL && state_q == ST_NORMAL && selSeen
    |=> state_q == ST_SHORTHOLD && !absorbOn)
    else $error("select change in normal missed");
  AST_SHORT_RETURN: assert property (
    frameRise && modeCode == `DSRC_MODE_NORMAL && state_q == ST_SHORTHOLD && !selSeen
    |=> state_q == ST_NORMAL && activeRef == $past(refSelect))
    else $error("short holdover did not adopt reference");
  AST_ABSORB_OFF: assert property (
    (state_q != $past(state_q)) && !(state_q == ST_NORMAL && $past(fromHold))
    |-> !absorbOn)
    else $error("absorption left on after state change");
  AST_ABSORB_PIN: assert property (
    (state_q == ST_NORMAL) && $past(fromHold) && ($past(state_q) != ST_NORMAL)
    |-> absorbOn == $past(phaseStepAbsorbEnable))
    else $error("absorption not taken from input");
  AST_INDICATORS: assert property (
    normalInd == (state_q == ST_NORMAL) && holdInd == (state_q == ST_HOLDOVER) &&
    freerunInd == (state_q == ST_FREERUN))
    else $error("indicator disagrees with state");
  AST_FREE_QUIET: assert property (
    state_q == ST_FREERUN |-> !selRefPulse && dcoSource == SRC_MASTER)
    else $error("freerun used a reference");
  AST_ROUTE: assert property (
    selRefPulse |-> $past(edgeP[activeRef]) && normalInd)
    else $error("pulse not from the selected reference");
  AST_RESERVED: assert property (
    frameRise && modeCode == `DSRC_MODE_RSVD |=> $stable(state_q))
    else $error("reserved code moved state");
  AST_HELD_WORD: assert property (
    inHold_q && !$past(inHold_q) |-> heldWord == $past(olderWord))
    else $error("held word not the older slot");

  COV_AUTO_CYCLE: cover property (state_q == ST_AUTOHOLD ##1 state_q == ST_NORMAL);
  COV_SHORT_CYCLE: cover property (state_q == ST_SHORTHOLD ##1 state_q == ST_NORMAL);
  COV_HOLD_ENTRY: cover property (state_q == ST_NORMAL ##1 state_q == ST_HOLDOVER);
  COV_RSVD_KEEP: cover property (frameRise && modeCode == `DSRC_MODE_RSVD && holdInd);
endmodule

//--- testbench/dsrc_ref_model.sv
// Purpose: Reference clock source model for the state controller
// Assumes: Clocks synchronous to clk, toggled just after the rising edge
// Notes:   Half period of zero stops a clock low, as on signal loss
`timescale 1ns/100ps
module dsrc_ref_model (
  input  wire logic        clk,
  input  wire logic [15:0] halfA,
  input  wire logic [15:0] halfB,
  output logic             referenceA,
  output logic             referenceB
);
  logic [15:0] cntA;
  logic [15:0] cntB;

  // Reference A divider
  always_ff @(posedge clk) begin
    if (halfA == 16'h0) begin
      referenceA <= 1'b0;
      cntA       <= 16'h0;
    end else if (cntA >= halfA - 16'h1) begin
      referenceA <= ~referenceA;
      cntA       <= 16'h0;
    end else begin
      cntA <= cntA + 16'h1;
    end
  end

  // Reference B divider
  always_ff @(posedge clk) begin
    if (halfB == 16'h0) begin
      referenceB <= 1'b0;
      cntB       <= 16'h0;
    end else if (cntB >= halfB - 16'h1) begin
      referenceB <= ~referenceB;
      cntB       <= 16'h0;
    end else begin
      cntB <= cntB + 16'h1;
    end
  end
endmodule

//--- testbench/dpll_state_reference_control_tb.sv
// Purpose: Self-checking bench of the reference state controller
// Assumes: Bench makes a frame pulse every 20 cycles
// Notes:   Short monitor and store counts keep the run brief
`timescale 1ns/100ps
module dpll_state_reference_control_tb import dsrc_pkg::*; ;
  localparam int unsigned MonCycles   = 25000;
  localparam int unsigned StoreCycles = 50;

  logic        clk, rst, framePulse8k, refSelect, loopLocked;
  logic        opStatePickLo, opStatePickHi, phaseStepAbsorbEnable, fastAcquireEnable;
  logic        ref0RatePickLo, ref0RatePickHi, ref1RatePickLo, ref1RatePickHi;
  logic [15:0] halfA, halfB;
  logic [31:0] freqWord = 32'h0;
  logic [31:0] heldWord;
  logic        referenceA, referenceB, normalInd, holdInd, freerunInd, fastLockOn;
  logic        absorbOn, activeRef, selRefPulse, refInvalid, refAOffsetFlag, refBOffsetFlag;
  dsrc_src_e   dcoSource;
  int          errorCnt, checks;

  dsrc_state_ctrl #(
    .MON_CYCLES  (MonCycles),
    .STORE_CYCLES(StoreCycles)
  ) u_dut (
    .clk(clk), .rst(rst), .framePulse8k(framePulse8k),
    .opStatePickLo(opStatePickLo), .opStatePickHi(opStatePickHi), .refSelect(refSelect),
    .phaseStepAbsorbEnable(phaseStepAbsorbEnable), .fastAcquireEnable(fastAcquireEnable),
    .ref0RatePickLo(ref0RatePickLo), .ref0RatePickHi(ref0RatePickHi),
    .ref1RatePickLo(ref1RatePickLo), .ref1RatePickHi(ref1RatePickHi),
    .referenceA(referenceA), .referenceB(referenceB), .loopLocked(loopLocked),
    .freqWord(freqWord), .normalInd(normalInd), .holdInd(holdInd),
    .freerunInd(freerunInd), .fastLockOn(fastLockOn), .absorbOn(absorbOn),
    .activeRef(activeRef), .selRefPulse(selRefPulse), .dcoSource(dcoSource),
    .heldWord(heldWord), .refInvalid(refInvalid),
    .refAOffsetFlag(refAOffsetFlag), .refBOffsetFlag(refBOffsetFlag)
  );

  dsrc_ref_model u_ref (
    .clk(clk), .halfA(halfA), .halfB(halfB), .referenceA(referenceA), .referenceB(referenceB)
  );

  // Clock 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Running frequency word, so stored words show their age
  always @(posedge clk) freqWord <= freqWord + 32'h1;

  // Value compare
  task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errorCnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    $display("Counts: checks %0d errors %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // One frame: pulse high one cycle, then 19 low
  task automatic frame();
    framePulse8k <= 1'b1;
    @(posedge clk);
    framePulse8k <= 1'b0;
    repeat (19) @(posedge clk);
  endtask

  // Two-cycle reset with rate codes and Freerun selected
  task automatic doReset(input logic [1:0] rate0, input logic [15:0] half);
    rst                              <= 1'b1;
    {ref0RatePickHi, ref0RatePickLo} <= rate0;
    {ref1RatePickHi, ref1RatePickLo} <= 2'h1;
    {opStatePickHi, opStatePickLo}   <= 2'h2;
    refSelect                        <= 1'b0;
    phaseStepAbsorbEnable            <= 1'b1;
    fastAcquireEnable                <= 1'b0;
    @(posedge clk);
    halfA <= half;
    halfB <= half;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic pick(input logic useB);
    return useB ? referenceB : referenceA;
  endfunction

  // Pulses seen after a rise and after a fall of one reference
  task automatic edgeChk(input logic useB, input logic [1:0] exp);
    logic [1:0] seen;
    seen = 2'h0;
    do @(posedge clk); while (pick(useB) !== 1'b0);
    do @(posedge clk); while (pick(useB) !== 1'b1);
    repeat (6) begin
      @(posedge clk);
      seen[1] = seen[1] | selRefPulse;
    end
    do @(posedge clk); while (pick(useB) !== 1'b0);
    repeat (6) begin
      @(posedge clk);
      seen[0] = seen[0] | selRefPulse;
    end
    chkVal(seen, exp);
  endtask

  // Frames until the normal indicator reaches a level, bounded
  task automatic waitNorm(input logic want);
    int n;
    n = 0;
    while (normalInd !== want && n < 40) begin
      frame();
      n++;
    end
    chkVal(normalInd, want);
  endtask

  // Active edges and a select change in Normal
  task automatic edgeTest();
    {opStatePickHi, opStatePickLo} <= 2'h0;
    ref0RatePickLo                 <= 1'b1;
    frame();
    chkVal(normalInd, 1'b1);
    edgeChk(1'b0, 2'h2);
    refSelect <= 1'b1;
    frame();
    chkVal({normalInd, absorbOn}, 2'h0);
    chkVal(dcoSource, SRC_STORED);
    frame();
    chkVal({normalInd, absorbOn, activeRef}, 3'h7);
    edgeChk(1'b1, 2'h1);
    $display("Test edge done");
  endtask

  // Every mode code, indicators, absorption and stored word
  task automatic modeTest();
    logic [1:0]  code [6] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h3, 2'h2};
    logic [4:0]  expo [6] = '{5'h11, 5'h08, 5'h12, 5'h08, 5'h08, 5'h04};
    dsrc_src_e   src [6]  = '{SRC_LOOP, SRC_STORED, SRC_LOOP, SRC_STORED, SRC_STORED,
                              SRC_MASTER};
    logic [4:0]  prev;
    logic [31:0] age;
    prev = 5'h04;
    for (int i = 0; i < 6; i++) begin
      {opStatePickHi, opStatePickLo} <= code[i];
      fastAcquireEnable              <= (i == 0);
      repeat (120) @(posedge clk);
      chkVal({normalInd, holdInd, freerunInd, absorbOn}, prev[4:1]);
      frame();
      age = freqWord - heldWord;
      chkVal({normalInd, holdInd, freerunInd, absorbOn, fastLockOn}, expo[i]);
      chkVal(dcoSource, src[i]);
      if (i == 3) chkVal(age >= 32'd64 && age <= 32'd124, 1'b1);
      prev = expo[i];
    end
    $display("Test mode done");
  endtask

  // Reference loss, recovery, and a select change in Auto-Holdover
  task automatic autoTest();
    {opStatePickHi, opStatePickLo} <= 2'h0;
    frame();
    halfA <= 16'd0;
    waitNorm(1'b0);
    chkVal({holdInd, refInvalid, activeRef}, 3'h2);
    chkVal(dcoSource, SRC_STORED);
    halfA <= 16'd10;
    waitNorm(1'b1);
    chkVal({refInvalid, activeRef}, 2'h0);
    halfA <= 16'd0;
    waitNorm(1'b0);
    refSelect <= 1'b1;
    frame();
    chkVal({normalInd, absorbOn}, 2'h0);
    frame();
    chkVal({normalInd, activeRef}, 2'h3);
    $display("Test auto done");
  endtask

  // Offset flags: A exactly nominal, B lost
  task automatic monTest();
    halfA <= 16'd6250;
    halfB <= 16'd0;
    repeat (2 * MonCycles + 100) @(posedge clk);
    chkVal({refAOffsetFlag, refBOffsetFlag}, 2'h1);
    $display("Test monitor done");
  endtask

  // Falling edge active at the two line rates, each set through a reset
  task automatic rateTest();
    for (int r = 2; r < 4; r++) begin
      doReset(2'(r), 16'd8);
      {opStatePickHi, opStatePickLo} <= 2'h0;
      frame();
      edgeChk(1'b0, 2'h1);
    end
    $display("Test rate done");
  endtask

  // Main sequence
  initial begin
    framePulse8k = 1'b0;
    loopLocked   = 1'b1;
    halfA        = 16'h0;
    halfB        = 16'h0;
    doReset(2'h0, 16'd8);
    chkVal({freerunInd, normalInd, holdInd, absorbOn}, 4'h8);
    chkVal(dcoSource, SRC_MASTER);
    chkVal(heldWord, 32'h0);
    $display("Test reset done");
    edgeTest();
    doReset(2'h1, 16'd10);
    modeTest();
    autoTest();
    monTest();
    rateTest();
    wrap_up();
  end

  // Watchdog over the expected run length
  initial begin
    repeat (70000) @(posedge clk);
    errorCnt++;
    $display("ERROR %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule
